// [scsb_pkg.sv]
package scsb_pkg;

  // ****************************************************************
  // status byte layout (status word bits 40-47)
  // ****************************************************************
  localparam int unsigned STAT_POS_FIRST  = 40;
  localparam int unsigned STAT_POS_LAST   = 47;
  localparam int unsigned BIT_PCI_IDX     = 0;  // status word bit 40
  localparam int unsigned BIT_LEN_IDX     = 1;  // status word bit 41
  localparam int unsigned CW_PCI_POS      = 36;
  localparam logic [7:0]  STAT_RST        = 8'h00;
  localparam logic [15:0] COUNT_RST       = 16'h0000;

  // current command word fields used here
  typedef struct packed {
    logic        pci_req;
    logic        suppress_length_flag;
    logic        chain_data_flag;
    logic        chain_cmd_flag;
    logic        immediate;
    logic [15:0] byte_count;
  } scsb_cmd_s;

  // condition bits reported by other checkers (bits 42-47)
  typedef logic [5:0] scsb_other_t;

endpackage

// [scsb_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module scsb_flag
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  import scsb_pkg::*;

  // set wins over clear
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end
endmodule
`default_nettype wire

// [scsb_status.sv]
// Overview of operation
// R1: status byte held at word bits 40-47
// R2: status bits independent, may coexist
// R3: channel control check may carry spurious checks
// R4: program check may carry spurious protection
// R5: set bit 40 when command requests interrupt
// R6: bit 40 stored only clearing pending interrupt
// R7: set bit 41 on byte count mismatch
// R8: suppress-length without chain-data hides mismatch
// R9: chain-data reports mismatch regardless of suppress
// R10: mismatch without suppress blocks command chaining
// R11: immediate commands never flag length mismatch
// R12: bit 41 stored only clearing status or halt
// R13: length bit withheld until channel end
// R14: count past zero answers service with command
// R15: count exhaustion still flags unsuppressed mismatch
// R16: clear status byte after word stored
`timescale 1ns/1ps
`default_nettype none
module scsb_status
(
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // command sequencing
  input  wire logic                cmd_load_i,
  input  wire scsb_pkg::scsb_cmd_s cmd_i,
  input  wire logic                byte_xfer_i,
  // peripheral interface
  input  wire logic                service_in_i,
  input  wire logic                chan_end_i,
  input  wire logic                early_end_i,
  output logic                     command_out_o,
  // other subchannel conditions
  input  wire scsb_pkg::scsb_other_t other_set_i,
  // status word storage
  input  wire logic                store_ack_i,
  input  wire logic                halt_io_instruction_i,
  output logic [7:0]               status_byte_o,
  output logic                     status_pending_o,
  output logic                     chain_ok_o
);
  import scsb_pkg::*;

  // ****************************************************************
  // command state and byte counter
  // ****************************************************************
  scsb_cmd_s   cmd_r;
  logic [15:0] count_r;
  logic        exhausted_r;
  logic        mismatch_r;
  logic        chan_end_seen_r;
  logic        pci_pend_r;
  logic        len_set;
  logic        len_q;
  logic        stat_clr;
  logic [5:0]  other_q;
  logic        len_suppressed;
  logic        len_done_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cmd_r <= '0;
    else if (cmd_load_i)
      cmd_r <= cmd_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      count_r <= COUNT_RST;
    else if (cmd_load_i)
      count_r <= cmd_i.byte_count;
    else if (byte_xfer_i && count_r != 16'h0000)
      count_r <= count_r - 16'h0001;
  end

  // count used up, peripheral still asks for service
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      exhausted_r <= 1'b0;
    else if (cmd_load_i)
      exhausted_r <= 1'b0;
    else if (service_in_i && count_r == 16'h0000 && !cmd_r.immediate)
      exhausted_r <= 1'b1;  // [R15]
  end

  // terminate transfer toward the peripheral
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      command_out_o <= 1'b0;
    else
      command_out_o <= service_in_i && count_r == 16'h0000 && !cmd_load_i;  // [R14]
  end

  // ****************************************************************
  // length mismatch detection
  // ****************************************************************
  // suppressed only with suppress-length set and chain-data clear
  assign len_suppressed = cmd_r.suppress_length_flag && !cmd_r.chain_data_flag;  // [R8] [R9]

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      mismatch_r <= 1'b0;
    else if (cmd_load_i)
      mismatch_r <= 1'b0;
    else if (!cmd_r.immediate)  // [R11]
      mismatch_r <= mismatch_r || (chan_end_i && count_r != 16'h0000)
                    || (early_end_i && count_r != 16'h0000)
                    || (service_in_i && count_r == 16'h0000);  // [R7] [R15]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      chan_end_seen_r <= 1'b0;
    else if (cmd_load_i)
      chan_end_seen_r <= 1'b0;
    else if (chan_end_i)
      chan_end_seen_r <= 1'b1;
  end

  // ****************************************************************
  // length reporting
  // ****************************************************************
  // report only after channel end, once per command
  assign len_set = (chan_end_seen_r || chan_end_i) && !cmd_r.immediate
                   && !len_suppressed && !len_done_r
                   && (mismatch_r || exhausted_r
                       || (chan_end_i && count_r != 16'h0000));  // [R13] [R7] [R11]

  // a standing set would beat every later clear of the flag
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      len_done_r <= 1'b0;
    else if (cmd_load_i)
      len_done_r <= 1'b0;
    else if (len_set)
      len_done_r <= 1'b1;  // [R16]
  end

  // ****************************************************************
  // command chaining
  // ****************************************************************
  // chaining blocked by mismatch with suppress-length clear; immediates never mismatch
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      chain_ok_o <= 1'b0;
    else
      chain_ok_o <= chan_end_i && cmd_r.chain_cmd_flag
                    && !(!cmd_r.suppress_length_flag && !cmd_r.immediate
                         && (mismatch_r || exhausted_r || count_r != 16'h0000));  // [R10] [R11]
  end

  // ****************************************************************
  // program-controlled interrupt
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pci_pend_r <= 1'b0;
    else if (cmd_load_i && cmd_i.pci_req)
      pci_pend_r <= 1'b1;  // [R5]
    else if (store_ack_i)
      pci_pend_r <= 1'b0;  // [R6]
  end

  // ****************************************************************
  // status byte flags
  // ****************************************************************
  // clear once stored or halted
  assign stat_clr = store_ack_i || halt_io_instruction_i;  // [R16] [R12]

  scsb_flag u_len_flag
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .set_i     (len_set),
    .clr_i     (stat_clr),
    .flag_o    (len_q)
  );

  // independent sticky bits 42-47; several may stand together
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_other
      scsb_flag u_flag
      (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (other_set_i[g]),  // [R2] [R3] [R4]
        .clr_i     (stat_clr),
        .flag_o    (other_q[g])
      );
    end
  endgenerate

  // byte occupies word bits 40-47, bit 40 first
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      status_byte_o <= STAT_RST;
    else
      status_byte_o <= {other_q, len_q, pci_pend_r};  // [R1] [R6] [R12]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      status_pending_o <= 1'b0;
    else
      status_pending_o <= pci_pend_r || len_q || (|other_q);
  end

endmodule
`default_nettype wire

// [scsb_pcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scsb_pcu_model
(
  // clock
  input  wire logic clk_sys_i,
  // channel interface
  input  wire logic cmd_out_i,
  output logic      xfer_o,
  output logic      svc_o,
  output logic      end_o,
  output logic      early_o
);
  int hangs = 0;
  initial {xfer_o, svc_o, end_o, early_o} = 4'h0;
  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask
  // n bytes, then optional overrun request or early stop
  task automatic run(int n, bit ov, bit er);
    int w;
    repeat (n)
    begin
      step;
      {xfer_o, svc_o} = 2'h3;
    end
    step;
    {xfer_o, svc_o, early_o} = {1'b0, ov, er & ~ov};
    w = 0;
    while (ov && w < 8 && (w == 0 || cmd_out_i !== 1'b1))
    begin
      step;
      w++;
    end
    hangs += int'(ov && cmd_out_i !== 1'b1);
    if (ov)
      svc_o = 1'b0;
    step;
    {early_o, end_o} = 2'h1;
    step;
    end_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [scsb_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module scsb_status_monitor
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic                  cmd_load_i,
  input wire scsb_pkg::scsb_cmd_s   cmd_i,
  input wire logic                  service_in_i,
  input wire logic                  chan_end_i,
  input wire logic                  command_out_o,
  input wire scsb_pkg::scsb_other_t other_set_i,
  input wire logic                  store_ack_i,
  input wire logic [7:0]            status_byte_o,
  input wire logic                  status_pending_o,
  input wire logic                  chain_ok_o
);
  import scsb_pkg::*;
  logic hide_r;
  logic sli_r;
  logic ce_r;
  always_ff @(posedge clk_sys_i)
    if (rst_i)
      {hide_r, sli_r} <= 2'h0;
    else if (cmd_load_i)
      {hide_r, sli_r} <= {cmd_i.immediate | (cmd_i.suppress_length_flag
        & ~cmd_i.chain_data_flag), cmd_i.suppress_length_flag};
  // channel end seen for the current command
  always_ff @(posedge clk_sys_i)
    if (rst_i || cmd_load_i)
      ce_r <= 1'b0;
    else if (chan_end_i)
      ce_r <= 1'b1;
  // ****
  // assertions
  // ****
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence pci_shown;
    ##2 status_byte_o[0];
  endsequence
  sequence len_rise;
    $rose(status_byte_o[1]);
  endsequence
  pci_set_a: assert property (cmd_load_i && cmd_i.pci_req |-> pci_shown)
    else $error("interrupt bit missing");
  len_hidden_a: assert property (len_rise |-> !hide_r)
    else $error("length bit not suppressed");
  len_wait_a: assert property (len_rise |-> $past(ce_r))
    else $error("length bit before channel end");
  len_pend_a: assert property (len_rise |-> ##[0:1] status_pending_o)
    else $error("pending missing");
  cmd_out_a: assert property ($rose(command_out_o) |-> $past(service_in_i))
    else $error("command out without service");
  clear_a: assert property (store_ack_i && !cmd_load_i && !chan_end_i
    && other_set_i == '0 |-> ##2 status_byte_o == 8'h00) else $error("byte not cleared");
  other_a: assert property (other_set_i[0] |-> ##[1:2] status_byte_o[2])
    else $error("bit 42 missing");
  chain_a: assert property (chain_ok_o && !sli_r |-> ##1 !status_byte_o[1])
    else $error("chaining after mismatch");
endmodule
bind scsb_status scsb_status_monitor i_mon (.clk_sys_i, .rst_i, .cmd_load_i, .cmd_i,
  .service_in_i, .chan_end_i, .command_out_o, .other_set_i, .store_ack_i,
  .status_byte_o, .status_pending_o, .chain_ok_o);
`default_nettype wire

// [subchannel_status_byte_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module subchannel_status_byte_tb;
  import scsb_pkg::*;
  logic        clk_sys_i = 0, rst_i = 1, cmd_load_i = 0, store_ack_i = 0, seen = 0;
  logic        halt_io_instruction_i = 0, byte_xfer_i, service_in_i, chan_end_i;
  logic        early_end_i, command_out_o, status_pending_o, chain_ok_o;
  logic [7:0]  status_byte_o;
  scsb_cmd_s   cmd_i = '0;
  scsb_other_t other_set_i = '0;
  int          n_fail = 0, total_checks = 0, n_cmd_out = 0;
  scsb_status i_dut (.clk_sys_i, .rst_i, .cmd_load_i, .cmd_i, .byte_xfer_i, .service_in_i,
    .chan_end_i, .early_end_i, .command_out_o, .other_set_i, .store_ack_i,
    .halt_io_instruction_i, .status_byte_o, .status_pending_o, .chain_ok_o);
  scsb_pcu_model i_pcu (.clk_sys_i, .cmd_out_i(command_out_o), .xfer_o(byte_xfer_i),
    .svc_o(service_in_i), .end_o(chan_end_i), .early_o(early_end_i));
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    if (cmd_load_i)
      seen <= 1'b0;
    else if (chain_ok_o === 1'b1)
      seen <= 1'b1;
    if (command_out_o === 1'b1)
      n_cmd_out <= n_cmd_out + 1;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // load one command word and let the peripheral run it
  task automatic go(logic pc, sl, cd, im, logic [15:0] cnt, int n, bit ov, er);
    cmd_i = '{pc, sl, cd, 1'b1, im, cnt};
    cmd_load_i = 1;
    tick(1);
    cmd_load_i = 0;
    i_pcu.run(n, ov, er);
    tick(3);
  endtask
  task automatic store;
    store_ack_i = 1;
    tick(1);
    store_ack_i = 0;
    tick(3);
    chk("cleared", 8'h00, status_byte_o);
    chk("pending cleared", 8'h00, 8'(status_pending_o));
  endtask
  // ****
  // scenarios
  // ****
  initial
  begin
    tick(20);
    rst_i = 0;
    chk("reset", 8'h00, status_byte_o);
    go(1, 0, 0, 0, 16'h0002, 2, 0, 0);
    chk("exact", 8'h01, status_byte_o);
    chk("chain exact", 8'h01, 8'(seen));
    chk("pending exact", 8'h01, 8'(status_pending_o));
    store;
    go(0, 0, 0, 0, 16'h0002, 1, 0, 1);
    chk("short", 8'h02, status_byte_o);
    chk("chain", 8'h00, 8'(seen));
    store;
    go(0, 1, 0, 0, 16'h0002, 1, 0, 1);
    chk("suppressed", 8'h00, status_byte_o);
    store;
    go(0, 0, 0, 1, 16'h0002, 0, 0, 0);
    chk("immediate", 8'h00, status_byte_o);
    chk("chain immediate", 8'h01, 8'(seen));
    store;
    go(0, 0, 0, 0, 16'h0001, 1, 1, 0);
    chk("overrun", 8'h02, status_byte_o);
    store;
    go(0, 1, 0, 0, 16'h0001, 1, 1, 0);
    chk("overrun hidden", 8'h00, status_byte_o);
    store;
    go(0, 1, 1, 0, 16'h0002, 1, 0, 1);
    other_set_i = 6'h3f;
    tick(1);
    other_set_i = 6'h00;
    tick(2);
    chk("all bits", 8'hfe, status_byte_o);
    halt_io_instruction_i = 1;
    tick(1);
    halt_io_instruction_i = 0;
    tick(3);
    chk("halt", 8'h00, 8'(status_byte_o[1]));
    store;
    chk("hangs", 8'h00, 8'(i_pcu.hangs));
    chk("command out", 8'h02, 8'(n_cmd_out));
    give_verdict;
  end
  initial
  begin
    #200000;
    n_fail++;
    give_verdict;
  end
endmodule
`default_nettype wire
